// ==== poc_pkg.sv ====
package poc_pkg;

    // converter geometry
    localparam int POC_DATA_W = 10;
    localparam int POC_LATENCY = 6;
    localparam int POC_DIGIT_W = 2;

    // register port geometry
    localparam int POC_REG_AW = 8;
    localparam int POC_REG_DW = 32;

    // register offsets (byte addresses)
    localparam logic [7:0] POC_OFS_STATUS = 8'h00;
    localparam logic [7:0] POC_OFS_MASK = 8'h04;
    localparam logic [7:0] POC_OFS_INFO = 8'h08;

    // status and mask bit positions
    localparam int POC_ST_RANGE = 0;
    localparam int POC_ST_WAKE = 1;
    localparam int POC_ST_W = 2;
    localparam logic [1:0] POC_MASK_RST = 2'h0;

    // info register field positions
    localparam int POC_INFO_MODE_LSB = 0;
    localparam int POC_INFO_TWOS = 2;
    localparam int POC_INFO_STAB = 3;
    localparam int POC_INFO_RUN = 4;
    localparam int POC_INFO_VALID = 5;

    // four-level select input, quantised by the pad to two bits
    localparam logic [1:0] POC_SEL_GND = 2'h0;
    localparam logic [1:0] POC_SEL_THIRD = 2'h1;
    localparam logic [1:0] POC_SEL_TWO_THIRD = 2'h2;
    localparam logic [1:0] POC_SEL_FULL = 2'h3;

    // power / output mode, gray coded along normal-hiz-nap-sleep
    typedef enum logic [1:0] {
        POC_NORMAL = 2'b00,
        POC_HIZ = 2'b01,
        POC_NAP = 2'b11,
        POC_SLEEP = 2'b10
    } poc_mode_t;

endpackage

// ==== poc_adc_ctrl.sv ====
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// How it works
// R01: a new sample is taken at each rising edge of the sample clock
// R02: input tracked between edges, held value captured exactly at the edge
// R03: result leaves the output register six clocks after its sample
// R04: per-stage digits are time aligned and merged before the output
// R05: data and flag driven only with power-down low and enable low
// R06: power-down low, enable high: keep converting, outputs floated
// R07: power-down high floats outputs; enable low naps, high sleeps
// R08: select level picks number format and duty stabiliser setting
// R09: result is a ten-bit word, bit nine most significant
// R10: range flag high when input was above or below full scale
// R11: two's complement is offset binary with the top bit inverted
// R12: range flag rides the pipeline with its sample, code saturated
module poc_adc_ctrl
    import poc_pkg::*;
#(
    parameter int DATA_W = POC_DATA_W,
    parameter int LATENCY = POC_LATENCY
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic signed [DATA_W+1:0] analog_level,
    input wire logic power_down_select,
    input wire logic output_enable_n,
    input wire logic [1:0] mode_select,
    output logic [DATA_W-1:0] sample_word,
    output logic sample_word_oe_n,
    output logic range_exceeded_flag,
    output logic flag_oe_n,
    output logic sample_valid,
    output logic stabiliser_on,
    input wire logic [POC_REG_AW-1:0] reg_addr,
    input wire logic [POC_REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [POC_REG_DW-1:0] reg_rdata,
    output logic irq
);

    // digit stages between the held sample and the correction register
    localparam int NSTG = DATA_W / POC_DIGIT_W;

    // refuse geometries the two-bit-per-stage pipeline cannot build
    generate
        if ((DATA_W % POC_DIGIT_W) != 0)
        begin : g_bad_width
            $error("poc_adc_ctrl: DATA_W must be a multiple of two");
        end
        if (DATA_W < 4)
        begin : g_bad_narrow
            $error("poc_adc_ctrl: DATA_W below four leaves no residue");
        end
        // range limits are worked out in int arithmetic
        if (DATA_W > 30)
        begin : g_bad_wide
            $error("poc_adc_ctrl: DATA_W above thirty overflows the limits");
        end
        if (LATENCY != NSTG + 1)
        begin : g_bad_latency
            $error("poc_adc_ctrl: LATENCY must be one hold plus DATA_W/2");
        end
    endgenerate

    // analog limits of the convertible range, in input units
    localparam logic signed [DATA_W+1:0] A_MAX =
        (DATA_W+2)'((2 ** (DATA_W - 1)) - 1);
    localparam logic signed [DATA_W+1:0] A_MIN =
        (DATA_W+2)'(-(2 ** (DATA_W - 1)));

    typedef struct packed {
        // mode and pad control
        poc_mode_t mode;
        logic drv_n;
        logic twos;
        logic stab;
        // per stage: residue, aligned digits, range and valid marks
        logic [NSTG:0][DATA_W-1:0] res;
        logic [NSTG:0][DATA_W-1:0] acc;
        logic [NSTG:0] ovr;
        logic [NSTG:0] vld;
        // output register
        logic [DATA_W-1:0] word;
        logic flag;
        logic wvld;
        // software-visible registers
        logic [POC_ST_W-1:0] status;
        logic [POC_ST_W-1:0] mask;
        logic [POC_REG_DW-1:0] rdata;
    } poc_state_t;

    // outputs float and the converter is asleep until pins are seen
    localparam poc_state_t ST_RST = '{
        mode: POC_SLEEP,
        drv_n: 1'b1,
        mask: POC_MASK_RST,
        default: '0
    };

    // pin pair to power/output mode
    function automatic poc_mode_t mode_from_pins(input logic pd,
        input logic oe_n);
        poc_mode_t m;
        m = POC_NORMAL;
        if (pd && oe_n)
            m = POC_SLEEP; // [R07]
        else if (pd)
            m = POC_NAP; // [R07]
        else if (oe_n)
            m = POC_HIZ; // [R06]
        return m;
    endfunction

    // true while the pipeline is clocked through
    function automatic logic runs(input poc_mode_t m);
        return (m == POC_NORMAL) || (m == POC_HIZ);
    endfunction

    // format half of the four-level select
    function automatic logic sel_twos(input logic [1:0] sel);
        return (sel == POC_SEL_TWO_THIRD) || (sel == POC_SEL_FULL); // [R08]
    endfunction

    // stabiliser half of the four-level select
    function automatic logic sel_stab(input logic [1:0] sel);
        return (sel == POC_SEL_THIRD) || (sel == POC_SEL_TWO_THIRD); // [R08]
    endfunction

    // true when the level lies outside the convertible range
    function automatic logic beyond_range(
        input logic signed [DATA_W+1:0] a
    );
        return (a > A_MAX) || (a < A_MIN); // [R10]
    endfunction

    // level to offset binary, pinned to the rail it crossed
    function automatic logic [DATA_W-1:0] clip_code(
        input logic signed [DATA_W+1:0] a
    );
        logic [DATA_W-1:0] c;
        c = {~a[DATA_W-1], a[DATA_W-2:0]};
        if (a > A_MAX)
            c = '1; // [R12]
        else if (a < A_MIN)
            c = '0; // [R12]
        return c;
    endfunction

    // number format at the output: two's complement flips the top bit
    function automatic logic [DATA_W-1:0] fmt_word(
        input logic [DATA_W-1:0] code,
        input logic twos
    );
        return twos ? {~code[DATA_W-1], code[DATA_W-2:0]} : code; // [R11]
    endfunction

    // read-back image of mode, format and pipeline state
    function automatic logic [POC_REG_DW-1:0] info_word(
        input poc_mode_t m,
        input logic twos,
        input logic stab,
        input logic run,
        input logic vld
    );
        logic [POC_REG_DW-1:0] w;
        w = '0;
        w[POC_INFO_MODE_LSB +: 2] = m;
        w[POC_INFO_TWOS] = twos;
        w[POC_INFO_STAB] = stab;
        w[POC_INFO_RUN] = run;
        w[POC_INFO_VALID] = vld;
        return w;
    endfunction

    // register address match
    function automatic logic hit(input logic [POC_REG_AW-1:0] a,
                                 input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // reset release synchroniser, asserts at once and releases late
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // only the second stage is read; the first may still be settling
    assign rst_n = rst_sync_q[1];

    // registered state and its next value
    poc_state_t q;
    poc_state_t d;

    // next-state logic for the whole block
    always_comb
    begin
        logic beyond;
        logic [DATA_W-1:0] held;
        logic [DATA_W-1:0] code;
        logic [1:0] digit;
        logic [POC_ST_W-1:0] clr;
        logic [POC_ST_W-1:0] ev;
        logic run;
        beyond = 1'b0;
        held = '0;
        code = '0;
        digit = 2'h0;
        clr = '0;
        ev = '0;
        run = 1'b0;
        // everything holds unless a rule below moves it
        d = q;

        // mode follows the pins one clock late, like the select pin
        d.mode = mode_from_pins(power_down_select, output_enable_n);
        d.drv_n = (d.mode != POC_NORMAL); // [R05] [R06] [R07]
        d.twos = sel_twos(mode_select); // [R08]
        d.stab = sel_stab(mode_select); // [R08]
        run = runs(q.mode);

        // out-of-range detect and clip onto the rails
        beyond = beyond_range(analog_level); // [R10]
        held = clip_code(analog_level); // [R12]

        if (run)
        begin
            // the edge itself is the hold instant; input tracked before
            d.res[0] = held; // [R01] [R02]
            d.acc[0] = '0;
            d.ovr[0] = beyond; // [R10]
            d.vld[0] = 1'b1;
            // each stage takes two bits and passes on the residue
            for (int k = 1; k <= NSTG; k++)
            begin
                digit = q.res[k-1][DATA_W-1 -: POC_DIGIT_W];
                d.res[k] = {q.res[k-1][DATA_W-3:0], 2'b00};
                // digits shift in so they line up at the end [R04]
                d.acc[k] = {q.acc[k-1][DATA_W-3:0], digit};
                d.ovr[k] = q.ovr[k-1]; // [R12]
                d.vld[k] = q.vld[k-1];
            end
            // correction and format at the output register [R03] [R04]
            code = q.acc[NSTG];
            d.word = fmt_word(code, q.twos); // [R11]
            d.flag = q.ovr[NSTG]; // [R12]
            d.wvld = q.vld[NSTG];
        end
        else
        begin
            // nap and sleep stop the converter; results in flight die
            d.vld = '0;
            d.wvld = 1'b0;
        end

        // events: a flagged word leaving, and waking into conversion
        ev[POC_ST_RANGE] = d.wvld && d.flag;
        ev[POC_ST_WAKE] = !run && runs(d.mode);

        // register writes, write one to clear; a new event wins
        if (reg_wr && hit(reg_addr, POC_OFS_STATUS))
            clr = reg_wdata[POC_ST_W-1:0];
        d.status = (q.status & ~clr) | ev;
        // mask is plain read/write; reset closes every source
        if (reg_wr && hit(reg_addr, POC_OFS_MASK))
            d.mask = reg_wdata[POC_ST_W-1:0];

        // read data stand for the one cycle after the strobe only
        d.rdata = '0;
        if (reg_rd)
        begin
            if (hit(reg_addr, POC_OFS_STATUS))
                d.rdata[POC_ST_W-1:0] = q.status;
            else if (hit(reg_addr, POC_OFS_MASK))
                d.rdata[POC_ST_W-1:0] = q.mask;
            else if (hit(reg_addr, POC_OFS_INFO))
                d.rdata = info_word(q.mode, q.twos, q.stab, run, q.wvld);
        end
    end

    // single state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= ST_RST;
        else
            q <= d;
    end

    // pads: values always present, the enables say when they count
    assign sample_word = q.word; // [R09]
    assign range_exceeded_flag = q.flag; // [R10]
    assign sample_word_oe_n = q.drv_n; // [R05]
    assign flag_oe_n = q.drv_n; // [R05]
    assign sample_valid = q.wvld;
    assign stabiliser_on = q.stab;
    assign reg_rdata = q.rdata;

    // level interrupt from any unmasked sticky bit
    assign irq = |(q.status & q.mask);

endmodule

// ==== poc_adc_ctrl_asserts.sv ====
`timescale 1ns/1ps
module poc_adc_ctrl_chk
#(
    parameter int DATA_W = 10
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic signed [DATA_W+1:0] analog_level,
    input wire logic power_down_select,
    input wire logic output_enable_n,
    input wire logic [1:0] mode_select,
    input wire logic [DATA_W-1:0] sample_word,
    input wire logic sample_word_oe_n,
    input wire logic range_exceeded_flag,
    input wire logic flag_oe_n,
    input wire logic sample_valid,
    input wire logic stabiliser_on,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    logic [3:0] up_q;
    // settle count: keeps $past from seeing edges before or during reset
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            up_q <= 4'h0;
        else if (up_q != 4'hF)
            up_q <= up_q + 4'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst || up_q != 4'hF);
    chk_oe_mode: assert property (sample_word_oe_n ==
        ($past(power_down_select) | $past(output_enable_n)))
        else $error("pad enable does not follow mode pins");
    chk_flag_oe: assert property (flag_oe_n == sample_word_oe_n)
        else $error("flag enable differs from word enable");
    chk_flag_align: assert property (sample_valid |->
        range_exceeded_flag == ($past(analog_level, 7) > 511 ||
        $past(analog_level, 7) < -512))
        else $error("range flag not aligned with its sample");
    chk_word_sat: assert property (sample_valid && range_exceeded_flag
        |-> sample_word[DATA_W-2:0] inside {'1, '0})
        else $error("out of range word not saturated");
    chk_valid_run: assert property (sample_valid
        |-> !$past(power_down_select, 3))
        else $error("result after power down");
    chk_nap_quiet: assert property ($past(power_down_select, 2) &&
        $past(power_down_select, 3) && $past(power_down_select, 4)
        |-> !sample_valid && $stable(sample_word))
        else $error("conversion ran while powered down");
    chk_stab_mode: assert property ($past(mode_select) ==
        $past(mode_select, 2) |-> stabiliser_on ==
        ($past(mode_select) == 2'h1 || $past(mode_select) == 2'h2))
        else $error("stabiliser does not follow select");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule
bind poc_adc_ctrl poc_adc_ctrl_chk #(.DATA_W(DATA_W)) poc_adc_ctrl_chk_inst (
    .clk, .nrst, .analog_level, .power_down_select, .output_enable_n,
    .mode_select, .sample_word, .sample_word_oe_n, .range_exceeded_flag,
    .flag_oe_n, .sample_valid, .stabiliser_on, .reg_rd, .reg_rdata);

// ==== poc_capture_model.sv ====
`timescale 1ns/1ps
module poc_capture_model
    import poc_pkg::*;
(
    input wire logic clk,
    input wire logic [POC_DATA_W-1:0] sample_word,
    input wire logic sample_word_oe_n,
    output logic [POC_DATA_W-1:0] pad_word
);
    logic [POC_DATA_W-1:0] last_q;
    // floating pads read as the inverse of the last driven word
    always_ff @(posedge clk)
        if (!sample_word_oe_n)
            last_q <= sample_word;
    assign pad_word = sample_word_oe_n ? ~last_q : sample_word;
endmodule

// ==== pipelined_adc_output_control_tb.sv ====
`timescale 1ns/1ps
module pipelined_adc_output_control_tb;
    import poc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic signed [11:0] analog_level = 12'sh000;
    logic power_down_select = 1'b1;
    logic output_enable_n = 1'b1;
    logic [1:0] mode_select = 2'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [9:0] sample_word, pad_word, c;
    logic sample_word_oe_n, range_exceeded_flag, flag_oe_n, sample_valid;
    logic stabiliser_on, irq;
    logic [31:0] reg_rdata, rv;
    int mismatches = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    poc_adc_ctrl poc_adc_ctrl_inst (.clk, .nrst, .analog_level,
        .power_down_select, .output_enable_n, .mode_select, .sample_word,
        .sample_word_oe_n, .range_exceeded_flag, .flag_oe_n, .sample_valid,
        .stabiliser_on, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq);
    poc_capture_model poc_capture_model_inst (.clk, .sample_word,
        .sample_word_oe_n, .pad_word);
    task automatic chk(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk);
            power_down_select <= m[1];
            output_enable_n <= m[0];
            cyc(9);
            chk("oe_n", sample_word_oe_n, m != 0);
            chk("flag_oe_n", flag_oe_n, m != 0);
            chk("valid", sample_valid, !m[1]);
            if (m == 0)
                chk("pad", pad_word, sample_word);
            rd(POC_OFS_INFO);
            chk("mode", rv[1:0], {m[1], m[1] ^ m[0]});
            chk("run", rv[POC_INFO_RUN], !m[1]);
        end
    endtask
    task automatic t_conv;
        int lv[6] = '{-700, -512, -1, 0, 511, 600};
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            power_down_select <= 1'b0;
            output_enable_n <= 1'b0;
            mode_select <= s[1:0];
            cyc(10);
            chk("stab", stabiliser_on, s == 1 || s == 2);
            for (int i = 0; i < 13; i++)
            begin
                @(posedge clk);
                analog_level <= 12'(lv[i % 6]);
                #1;
                if (i >= 7)
                begin
                    c = lv[i-7] > 511 ? 10'h3FF : 10'(lv[i-7] + 512);
                    if (lv[i-7] < -512)
                        c = 10'h000;
                    if (s[1])
                        c[9] = ~c[9];
                    chk("word", sample_word, c);
                    chk("flag", range_exceeded_flag,
                        lv[i-7] > 511 || lv[i-7] < -512);
                end
            end
        end
        @(posedge clk);
        analog_level <= 12'sh000;
    endtask
    // range event: sticky, masked, then cleared by a written one
    task automatic t_irq;
        cyc(10);
        rd(POC_OFS_STATUS);
        chk("status_old", rv, 32'h3);
        wr(POC_OFS_STATUS, 32'h3);
        rd(8'h0C);
        chk("unmapped", rv, 32'h0);
        rd(POC_OFS_STATUS);
        chk("status", rv, 32'h0);
        @(posedge clk);
        analog_level <= 12'sh300;
        cyc(9);
        chk("irq_masked", irq, 1'b0);
        wr(POC_OFS_MASK, 32'h1);
        cyc(1);
        chk("irq_on", irq, 1'b1);
        rd(POC_OFS_STATUS);
        chk("status_set", rv, 32'h1);
        @(posedge clk);
        analog_level <= 12'sh000;
        cyc(9);
        wr(POC_OFS_STATUS, 32'h1);
        cyc(1);
        chk("irq_off", irq, 1'b0);
    endtask
    task automatic final_report;
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        cyc(4);
        rd(POC_OFS_MASK);
        chk("mask_rst", rv, 32'h0);
        t_modes();
        t_conv();
        t_irq();
        final_report();
    end
endmodule
